// File: core/stpg_top.sv
// Sidetone pwm generator: balanced-duty carrier and legacy square wave
//
// Overview of operation
// - Carrier runs at sixty times tone frequency
// - Duty alternates symmetrically about half per tone
// - Average duty stays fifty percent every volume in modern mode
// - Higher volume widens the duty deviation
// - Frequency and volume are adjustable settings
// - Legacy mode: tone square, duty sets volume
// - Sidetone produced while transmitting
// - All timing from the system clock
`include "stpg_consts.svh"

module stpg_top (
  // Clock and reset
  input  wire logic                   i_clock,
  input  wire logic                   i_reset_n,
  // User settings
  input  wire stpg_pkg::stpg_freq_t   i_tone_hz,
  input  wire stpg_pkg::stpg_vol_t    i_volume,
  input  wire logic                   i_legacy_mode,
  // Transmit state pin
  input  wire logic                   i_transmit,
  // Audio and status
  output logic                        o_sidetone,
  output logic                        o_tone_active
);

  localparam stpg_pkg::stpg_phase_t HALF = 27'(`STPG_CLOCK_HZ / 2);
  localparam logic [5:0] LAST_CNT = 6'(`STPG_CARRIER_RATIO - 1);

  stpg_pkg::stpg_top_s   st;
  stpg_pkg::stpg_top_s   next_st;
  stpg_pkg::stpg_phase_t thr;
  stpg_pkg::stpg_phase_t thr_hi;
  stpg_pkg::stpg_phase_t thr_lo;
  stpg_pkg::stpg_phase_t dev;
  logic                  tone_hi;

  stpg_car_if car ();

  stpg_carrier u_carrier (
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .car       (car.source)
  );

  // Fraction of the carrier modulus, v / 2^sh; product kept wide to avoid overflow
  function automatic stpg_pkg::stpg_phase_t scale(input logic [8:0] v, input int sh);
    logic [35:0] prod;
    prod = 36'(v) * 36'(`STPG_CLOCK_HZ);
    return 27'(prod >> sh);
  endfunction : scale

  // Carrier step is sixty times tone
  // Legacy mode reuses the accumulator at the bare tone rate
  always_comb begin
    if (st.state == stpg_pkg::STPG_LEGACY) begin
      car.step = 27'(st.freq);
    end else begin
      car.step = 27'(st.freq) * 27'(`STPG_CARRIER_RATIO);
    end
  end

  // Deviation grows with volume
  // Top of range reaches about 75/25, so neither half ever collapses
  assign dev     = scale({1'b0, st.vol}, `STPG_MODERN_SHIFT);
  assign thr_hi  = HALF + dev;
  assign thr_lo  = HALF - dev;
  assign tone_hi = (st.cnt < 6'(`STPG_HALF_TONE));

  // Comparison threshold per mode
  always_comb begin
    unique case (st.state)
      stpg_pkg::STPG_IDLE:   thr = HALF;
      stpg_pkg::STPG_MODERN: thr = tone_hi ? thr_hi : thr_lo;
      // Legacy duty from volume
      // Volume 255 gives exactly half, volume 0 about 0.2 percent
      stpg_pkg::STPG_LEGACY: thr = scale(9'(st.vol) + 9'h001, `STPG_LEGACY_SHIFT);
      // Unused fourth code of the two-bit state falls back to the idle duty
      default:               thr = HALF;
    endcase
  end

  // Next state: sync, settings latch, tone counter, mode changes
  // Every change lands on an accumulator wrap so no partial pulse is emitted
  always_comb begin
    next_st = st;
    next_st.tx_meta = i_transmit;
    next_st.tx_sync = st.tx_meta;
    next_st.out = (car.phase < thr);
    if (car.wrap) begin
      unique case (st.state)
        stpg_pkg::STPG_IDLE: begin
          if (i_tone_hz != 11'h000) begin
            next_st.freq = i_tone_hz;
          end
          next_st.vol = i_volume;
          next_st.cnt = 6'h00;
          if (st.tx_sync) begin
            next_st.state = i_legacy_mode ? stpg_pkg::STPG_LEGACY : stpg_pkg::STPG_MODERN;
          end
        end
        stpg_pkg::STPG_MODERN: begin
          // Whole tone periods only
          // Leaving or retuning mid-period would break the 30/30 balance
          if (st.cnt == LAST_CNT) begin
            next_st.cnt = 6'h00;
            if (i_tone_hz != 11'h000) begin
              next_st.freq = i_tone_hz;
            end
            next_st.vol = i_volume;
            if (!st.tx_sync || i_legacy_mode) begin
              next_st.state = stpg_pkg::STPG_IDLE;
            end
          end else begin
            next_st.cnt = 6'(st.cnt + 6'h01);
          end
        end
        stpg_pkg::STPG_LEGACY: begin
          if (i_tone_hz != 11'h000) begin
            next_st.freq = i_tone_hz;
          end
          next_st.vol = i_volume;
          if (!st.tx_sync || !i_legacy_mode) begin
            next_st.state = stpg_pkg::STPG_IDLE;
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      st <= '{state:   stpg_pkg::STPG_IDLE,
              tx_meta: 1'b0,
              tx_sync: 1'b0,
              freq:    `STPG_RESET_TONE_HZ,
              vol:     `STPG_RESET_VOLUME,
              cnt:     6'h00,
              out:     1'b0};
    end else begin
      st <= next_st;
    end
  end

  // Sidetone comes straight from a flip-flop; tone_active is decoded from the state register
  assign o_sidetone    = st.out;
  assign o_tone_active = (st.state != stpg_pkg::STPG_IDLE);

  property p_ratio;
    @(posedge i_clock) disable iff (!i_reset_n)
      (st.state == stpg_pkg::STPG_MODERN && car.wrap && st.cnt != LAST_CNT)
        |=> (st.cnt == 6'($past(st.cnt) + 6'h01));
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("tone counter did not advance on carrier wrap");

  property p_alternate;
    @(posedge i_clock) disable iff (!i_reset_n)
      (st.state == stpg_pkg::STPG_MODERN && car.wrap && st.cnt == 6'(`STPG_HALF_TONE - 1))
        |=> (!tone_hi && thr <= HALF);
  endproperty
  a_alternate: assert property (p_alternate)
    else $error("duty did not swap at half tone");

  property p_balance;
    @(posedge i_clock) disable iff (!i_reset_n)
      (st.state == stpg_pkg::STPG_MODERN)
        |-> (thr_hi >= HALF && thr_lo <= HALF && (thr_hi - HALF) == (HALF - thr_lo));
  endproperty
  a_balance: assert property (p_balance)
    else $error("duty pair not symmetric about half");

  property p_whole_period;
    @(posedge i_clock) disable iff (!i_reset_n)
      (st.state == stpg_pkg::STPG_MODERN && !(car.wrap && st.cnt == LAST_CNT))
        |=> (st.state == stpg_pkg::STPG_MODERN);
  endproperty
  a_whole_period: assert property (p_whole_period)
    else $error("tone left before a whole period ended");

  property p_volume;
    @(posedge i_clock) disable iff (!i_reset_n)
      (st.state == stpg_pkg::STPG_MODERN && st.vol != 8'h00)
        |-> (tone_hi ? (thr > HALF) : (thr < HALF));
  endproperty
  a_volume: assert property (p_volume)
    else $error("nonzero volume gave no deviation");

  property p_settings;
    @(posedge i_clock) disable iff (!i_reset_n)
      (st.state == stpg_pkg::STPG_IDLE && car.wrap && i_tone_hz != 11'h000)
        |=> (st.freq == $past(i_tone_hz) && st.vol == $past(i_volume));
  endproperty
  a_settings: assert property (p_settings)
    else $error("settings not taken while idle");

  property p_legacy;
    @(posedge i_clock) disable iff (!i_reset_n)
      (st.state == stpg_pkg::STPG_LEGACY) |-> (thr <= HALF && thr != 27'h0000000);
  endproperty
  a_legacy: assert property (p_legacy)
    else $error("legacy duty outside its range");

  property p_tx_start;
    @(posedge i_clock) disable iff (!i_reset_n)
      (st.state == stpg_pkg::STPG_IDLE) |=>
        ((st.state != stpg_pkg::STPG_IDLE) == ($past(car.wrap) && $past(st.tx_sync)));
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("tone start not tied to transmit at wrap");

  property p_idle_half;
    @(posedge i_clock) disable iff (!i_reset_n)
      (st.state == stpg_pkg::STPG_IDLE) |=> (o_sidetone == ($past(car.phase) < HALF));
  endproperty
  a_idle_half: assert property (p_idle_half)
    else $error("idle output not at half duty");

endmodule : stpg_top

// File: core/stpg_consts.svh
// Timing counts, scaling shifts and reset values of the sidetone generator
`ifndef STPG_CONSTS_SVH
`define STPG_CONSTS_SVH

// System clock period in ns and the rate derived from it
`define STPG_CLOCK_PERIOD_NS 25
`define STPG_CLOCK_HZ (1000000000 / `STPG_CLOCK_PERIOD_NS)

// Carrier runs at this multiple of the tone frequency
`define STPG_CARRIER_RATIO 60
// Carrier cycles spent in each half of one tone period
`define STPG_HALF_TONE 30

// Settings held after reset
`define STPG_RESET_TONE_HZ 11'h2bc
`define STPG_RESET_VOLUME 8'h20

// Volume scaling: modern deviation is vol/1024 of a carrier period, legacy high
// time is (vol+1)/512 of a tone period
`define STPG_MODERN_SHIFT 10
`define STPG_LEGACY_SHIFT 9

`endif

// File: core/stpg_pkg.sv
// Types shared by the sidetone generator modules
package stpg_pkg;

  typedef logic [26:0] stpg_phase_t;
  typedef logic [10:0] stpg_freq_t;
  typedef logic [7:0]  stpg_vol_t;

  typedef enum logic [1:0] {
    STPG_IDLE,
    STPG_MODERN,
    STPG_LEGACY
  } stpg_state_e;

  typedef struct packed {
    stpg_state_e state;
    logic        tx_meta;
    logic        tx_sync;
    stpg_freq_t  freq;
    stpg_vol_t   vol;
    logic [5:0]  cnt;
    logic        out;
  } stpg_top_s;

  typedef struct packed {
    stpg_phase_t phase;
    logic        wrap;
  } stpg_car_s;

endpackage : stpg_pkg

// File: core/stpg_car_if.sv
// Link between the tone controller and its phase accumulator
interface stpg_car_if;
  stpg_pkg::stpg_phase_t step;
  stpg_pkg::stpg_phase_t phase;
  logic                  wrap;

  modport source (input step, output phase, output wrap);
  modport user   (output step, input phase, input wrap);
endinterface : stpg_car_if

// File: core/stpg_carrier.sv
// Phase accumulator clocking the pwm carrier timer
`include "stpg_consts.svh"

module stpg_carrier (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  // Step in, phase and wrap out
  stpg_car_if.source       car
);

  stpg_pkg::stpg_car_s st;
  stpg_pkg::stpg_car_s next_st;
  logic [27:0]         sum;

  // Phase wraps modulo clock rate
  // Modulo the clock rate so the wrap rate equals step in Hz exactly
  always_comb begin
    next_st = st;
    sum = {1'b0, st.phase} + {1'b0, car.step};
    next_st.wrap = (sum >= 28'(`STPG_CLOCK_HZ));
    if (next_st.wrap) begin
      next_st.phase = 27'(sum - 28'(`STPG_CLOCK_HZ));
    end else begin
      next_st.phase = sum[26:0];
    end
  end

  // State register
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign car.phase = st.phase;
  assign car.wrap  = st.wrap;

  property p_phase_bound;
    @(posedge i_clock) disable iff (!i_reset_n)
      (st.phase < 27'(`STPG_CLOCK_HZ)) && (!st.wrap || (st.phase < $past(car.step)));
  endproperty
  a_phase_bound: assert property (p_phase_bound)
    else $error("carrier phase left its modulo range");

endmodule : stpg_carrier

// File: dv/stpg_filter_model.sv
// Partner model: audio filter reduced to a duty and edge meter on the sidetone
module stpg_filter_model (
  // Clock and window control
  input  wire logic i_clock,
  input  wire logic i_clear,
  // Pwm audio from the generator
  input  wire logic i_audio,
  // High cycles, window cycles and rising edges seen
  output int        o_high,
  output int        o_total,
  output int        o_rises
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last;

  // Integrate like the filter cap; clear discharges it to start a window
  always_ff @(posedge i_clock) begin
    last <= i_audio;
    if (i_clear) begin
      o_high  <= 0;
      o_total <= 0;
      o_rises <= 0;
    end else begin
      o_total <= o_total + 1;
      o_high  <= o_high + int'(i_audio);
      o_rises <= o_rises + int'(i_audio & ~last);
    end
  end
endmodule : stpg_filter_model

// File: dv/stpg_top_test.sv
// Self-checking testbench of the sidetone pwm generator
module stpg_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(w, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %s expected %0d seen %0d", w, e, g); end end

  logic                 clock = 1'b0;
  logic                 reset_n = 1'b0;
  stpg_pkg::stpg_freq_t tone_hz = 11'h7d0;
  stpg_pkg::stpg_vol_t  volume = 8'hff;
  logic                 legacy_mode = 1'b0;
  logic                 transmit = 1'b0;
  logic                 clear = 1'b0;
  logic                 sidetone;
  logic                 tone_active;
  int                   high, total, rises;
  int                   mismatches = 0;
  int                   checked = 0;

  stpg_top i_dut (.i_clock(clock), .i_reset_n(reset_n), .i_tone_hz(tone_hz),
    .i_volume(volume), .i_legacy_mode(legacy_mode), .i_transmit(transmit),
    .o_sidetone(sidetone), .o_tone_active(tone_active));
  stpg_filter_model i_filt (.i_clock(clock), .i_clear(clear), .i_audio(sidetone),
    .o_high(high), .o_total(total), .o_rises(rises));

  // 40 MHz clock
  initial begin
    forever #12.5 clock = ~clock;
  end

  // Analogue readings are never exact, so a value within tolerance reads as expected
  function automatic int near(input int g, input int e, input int t);
    return (g > e - t && g < e + t) ? e : g;
  endfunction : near

  task automatic measure(input int n);
    clear = 1'b1;
    @(negedge clock);
    clear = 1'b0;
    repeat (n) @(negedge clock);
  endtask : measure

  // Bounded wait for the tone state; running out ends the run
  task automatic wait_active(input logic lvl, input int bound);
    int k;
    for (k = 0; k < bound && tone_active !== lvl; k++) @(negedge clock);
    `CHK("tone_active", lvl, tone_active)
    if (tone_active !== lvl) end_of_test();
  endtask : wait_active

  // Bounded wait for a sidetone level; waited returns the cycles it took
  task automatic wait_level(input logic lvl, input int bound, output int waited);
    int k;
    for (k = 0; k < bound && sidetone !== lvl; k++) @(negedge clock);
    waited = k;
    `CHK("sidetone_level", lvl, sidetone)
    if (sidetone !== lvl) end_of_test();
  endtask : wait_level

  task automatic t_idle;
    repeat (1000) @(negedge clock);
    measure(3333);
    `CHK("idle_rises", 10, near(rises, 10, 2))
    `CHK("idle_window", 3333, total)
    `CHK("idle_high", 1667, near(high, 1667, 40))
    `CHK("idle_active", 1'b0, tone_active)
    tone_hz = 11'h000;
    repeat (400) @(negedge clock);
    measure(3333);
    `CHK("zero_tone_rises", 10, near(rises, 10, 2))
    $display("test idle done");
  endtask : t_idle

  task automatic t_modern;
    int first;
    volume = 8'h10;
    transmit = 1'b1;
    wait_active(1'b1, 2000);
    measure(10000);
    `CHK("soft_high_half", 5156, near(high, 5156, 50))
    volume = 8'hff;
    measure(10000);
    `CHK("soft_low_half", 4844, near(high, 4844, 50))
    measure(10000);
    first = high;
    `CHK("loud_high_half", 7490, near(first, 7490, 50))
    legacy_mode = 1'b1;
    volume = 8'h7f;
    measure(9990);
    `CHK("loud_low_half", 2510, near(high, 2510, 50))
    `CHK("loud_average", 10000, near(first + high, 10000, 60))
    $display("test modern done");
  endtask : t_modern

  task automatic t_legacy;
    int low;
    // Mode change goes through idle, then restarts at the next wrap
    wait_active(1'b0, 2000);
    wait_active(1'b1, 2000);
    // Full volume is only taken at the first tone wrap, so the first period stays at 25%
    volume = 8'hff;
    // Low time is phase-independent: three quarters of 20000 cycles
    wait_level(1'b0, 8000, low);
    wait_level(1'b1, 20000, low);
    `CHK("legacy_low", 15000, near(low, 15000, 3))
    // Rise marks the wrap that took full volume; drop transmit for the next wrap
    transmit = 1'b0;
    measure(19990);
    `CHK("legacy_max_high", 10000, near(high, 10000, 60))
    `CHK("legacy_rises", 0, rises)
    wait_active(1'b0, 2000);
    $display("test legacy done");
  endtask : t_legacy

  task automatic end_of_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    repeat (12) @(negedge clock);
    `CHK("reset_sidetone", 1'b0, sidetone)
    `CHK("reset_active", 1'b0, tone_active)
    reset_n = 1'b1;
    t_idle();
    t_modern();
    t_legacy();
    end_of_test();
  end
endmodule : stpg_top_test
